// ---- logic/sfs_pkg.sv ----
// Shared constants, types and register layout of the flash self-programming sequencer
`default_nettype none

package sfs_pkg;

    // ****************************************************************
    // Register offsets (APB byte addresses)
    // ****************************************************************
    localparam logic [7:0] SFS_OFF_CMD = 8'h00;
    localparam logic [7:0] SFS_OFF_PTR = 8'h04;
    localparam logic [7:0] SFS_OFF_DATA = 8'h08;
    localparam logic [7:0] SFS_OFF_ISSUE = 8'h0C;
    localparam logic [7:0] SFS_OFF_RESULT = 8'h10;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SFS_BIT_ARM = 0;
    localparam int SFS_BIT_ERASE = 1;
    localparam int SFS_BIT_WRITE = 2;
    localparam int SFS_BIT_LOCK = 3;
    localparam int SFS_BIT_REEN = 4;
    localparam int SFS_BIT_BUSY = 6;
    localparam int SFS_ISSUE_STORE = 0;
    localparam int SFS_ISSUE_LOAD = 1;
    localparam int SFS_LOCK_SRC_MSB = 5;
    localparam int SFS_LOCK_SRC_LSB = 2;

    // ****************************************************************
    // Command patterns in the low five bits
    // ****************************************************************
    localparam logic [4:0] SFS_CMD_NONE = 5'h00;
    localparam logic [4:0] SFS_CMD_LOAD = 5'h01;
    localparam logic [4:0] SFS_CMD_ERASE = 5'h03;
    localparam logic [4:0] SFS_CMD_WRITE = 5'h05;
    localparam logic [4:0] SFS_CMD_LOCK = 5'h09;
    localparam logic [4:0] SFS_CMD_REEN = 5'h11;

    // ****************************************************************
    // Arming windows, counted in clock cycles
    // ****************************************************************
    localparam logic [2:0] SFS_STORE_WIN = 3'h4;
    localparam logic [2:0] SFS_LOAD_WIN_MIN = 3'h2;
    localparam logic [2:0] SFS_WIN_LAST = 3'h1;

    // ****************************************************************
    // Reset and fill values
    // ****************************************************************
    localparam logic [5:0] SFS_LOCK_RESET = 6'h3F;
    localparam logic [1:0] SFS_LOCK_LB_KEEP = 2'h3;
    localparam logic [1:0] SFS_LOCK_RD_PAD = 2'h0;
    localparam logic [15:0] SFS_ERASED_WORD = 16'hFFFF;
    localparam logic [7:0] SFS_BLOCKED_BYTE = 8'hFF;

    typedef enum logic [1:0] {
        SFS_IDLE,
        SFS_ARMED,
        SFS_FLASH
    } sfs_state_t;

    typedef enum logic [1:0] {
        SFS_OP_NONE,
        SFS_OP_ERASE,
        SFS_OP_WRITE
    } sfs_op_t;

    typedef struct packed {
        logic start;
        sfs_op_t op;
        logic [15:0] addr;
    } sfs_flash_cmd_t;

    typedef struct packed {
        sfs_state_t state;
        logic [4:0] cmd;
        logic busy;
        logic [2:0] win;
        logic [15:0] ptr;
        logic [15:0] data;
        sfs_flash_cmd_t fcmd;
        logic halt;
        logic [5:0] lock;
        logic [7:0] result;
        logic load_pend;
        logic [15:0] rd_addr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sfs_regs_t;

    localparam sfs_regs_t SFS_REGS_RESET = '{
        state: SFS_IDLE,
        cmd: SFS_CMD_NONE,
        busy: 1'b0,
        win: 3'h0,
        ptr: 16'h0000,
        data: 16'h0000,
        fcmd: '{start: 1'b0, op: SFS_OP_NONE, addr: 16'h0000},
        halt: 1'b0,
        lock: SFS_LOCK_RESET,
        result: 8'h00,
        load_pend: 1'b0,
        rd_addr: 16'h0000,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0
    };

endpackage : sfs_pkg

`default_nettype wire

// ---- logic/sfs_sync.sv ----
// Two-flop synchroniser, also used to release the reset
`default_nettype none

module sfs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,              // Clock
    input wire logic rst_n_i,            // Async reset, active low
    input wire logic [WIDTH-1:0] d_i,    // Asynchronous input
    output logic [WIDTH-1:0] q_o         // Synchronised output
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sfs_sync_state_t;

    sfs_sync_state_t st_q;
    sfs_sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.s2;

endmodule : sfs_sync

`default_nettype wire

// ---- logic/sfs_page_buffer.sv ----
// Temporary page buffer with load-once tracking per word
`default_nettype none

module sfs_page_buffer import sfs_pkg::*; #(
    parameter int WORD_BITS = 6
) (
    input wire logic clk_i,                    // Clock
    input wire logic rst_n_i,                  // Reset, active low
    input wire logic clr_i,                    // Erase whole buffer
    input wire logic we_i,                     // Word load strobe
    input wire logic [WORD_BITS-1:0] waddr_i,  // Word in page to load
    input wire logic [15:0] wdata_i,           // Word to load
    input wire logic [WORD_BITS-1:0] raddr_i,  // Array read address
    output logic [15:0] rdata_o                // Array read data, registered
);

    localparam int WORDS = 2 ** WORD_BITS;

    typedef struct packed {
        logic [WORDS-1:0] loaded;
        logic [15:0] rdata;
    } sfs_buf_state_t;

    sfs_buf_state_t st_q;
    sfs_buf_state_t st_d;
    logic [15:0] mem_q [WORDS];
    logic first_load;

    assign first_load = we_i && !clr_i && !st_q.loaded[waddr_i];

    always_comb begin
        st_d = st_q;
        if (clr_i) begin
            st_d.loaded = '0;
        end else if (first_load) begin
            st_d.loaded[waddr_i] = 1'b1;
        end
        st_d.rdata = st_q.loaded[raddr_i] ? mem_q[raddr_i] : SFS_ERASED_WORD;
    end

    // Second load of a word is ignored until the buffer is erased
    always_ff @(posedge clk_i) begin
        if (first_load) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_o = st_q.rdata;

endmodule : sfs_page_buffer

`default_nettype wire

// ---- logic/sfs_sequencer.sv ----
// Flash self-programming sequencer with APB register access
`default_nettype none

module sfs_sequencer import sfs_pkg::*; #(
    parameter int WORD_BITS = 6,
    parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_BASE = 16'h3800
) (
    input wire logic clk_i,                    // Clock, 100 MHz
    input wire logic rst_n_i,                  // Async reset, active low
    input wire logic psel_i,                   // APB select
    input wire logic penable_i,                // APB enable
    input wire logic pwrite_i,                 // APB write
    input wire logic [7:0] paddr_i,            // APB byte address
    input wire logic [31:0] pwdata_i,          // APB write data
    input wire logic [3:0] pstrb_i,            // APB byte strobes
    output logic [31:0] prdata_o,              // APB read data
    output logic pready_o,                     // APB ready
    output logic pslverr_o,                    // APB error
    output sfs_flash_cmd_t fl_cmd_o,           // Flash array command
    input wire logic fl_done_i,                // Flash array operation done
    input wire logic [WORD_BITS-1:0] fl_buf_addr_i, // Array reads buffer word
    output logic [15:0] fl_buf_data_o,         // Buffer word to array
    output logic [15:0] fl_rd_addr_o,          // Byte address of ordinary load
    input wire logic [7:0] fl_rd_byte_i,       // Byte read for ordinary load
    input wire logic [7:0] fuse_i,             // Fuse bits from pins
    output logic [5:0] lock_bits_o,            // Boot lock bits, 0 = programmed
    output logic cpu_halt_o,                   // Stall CPU core
    output logic section_busy_o                // Read-while-write section blocked
);

    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    logic rst_n_s;
    logic [7:0] fuse_s;

    sfs_sync #(
        .WIDTH(1)
    ) u_rst_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(1'b1),
        .q_o(rst_n_s)
    );

    sfs_sync #(
        .WIDTH(8)
    ) u_fuse_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_s),
        .d_i(fuse_i),
        .q_o(fuse_s)
    );

    // ****************************************************************
    // State and decode
    // ****************************************************************
    localparam logic [15:0] PAGE_MASK = 16'hFFFF << (WORD_BITS + 1);

    sfs_regs_t st_q;
    sfs_regs_t st_d;

    logic apb_access;
    logic apb_take;
    logic addr_ok;
    logic cmd_wr;
    logic store_c;
    logic load_c;
    logic cmd_valid;
    logic tgt_rww;
    logic buf_we;
    logic buf_clr;

    assign apb_access = psel_i && penable_i;
    assign apb_take = apb_access && st_q.pready;
    assign addr_ok = (paddr_i == SFS_OFF_CMD) || (paddr_i == SFS_OFF_PTR) ||
                     (paddr_i == SFS_OFF_DATA) || (paddr_i == SFS_OFF_ISSUE) ||
                     (paddr_i == SFS_OFF_RESULT);
    assign cmd_wr = apb_take && pwrite_i && (paddr_i == SFS_OFF_CMD) && pstrb_i[0];
    assign store_c = apb_take && pwrite_i && (paddr_i == SFS_OFF_ISSUE) && pstrb_i[0] &&
                     pwdata_i[SFS_ISSUE_STORE];
    assign load_c = apb_take && pwrite_i && (paddr_i == SFS_OFF_ISSUE) && pstrb_i[0] &&
                    pwdata_i[SFS_ISSUE_LOAD] && !pwdata_i[SFS_ISSUE_STORE];
    assign tgt_rww = st_q.ptr < NO_READ_WHILE_WRITE_SECTION_BASE;

    // Only five command patterns are accepted
    always_comb begin
        case (pwdata_i[4:0])
            SFS_CMD_LOAD, SFS_CMD_ERASE, SFS_CMD_WRITE, SFS_CMD_LOCK, SFS_CMD_REEN: begin
                cmd_valid = 1'b1;
            end
            default: begin
                cmd_valid = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        buf_we = 1'b0;
        buf_clr = 1'b0;
        st_d.fcmd.start = 1'b0;
        st_d.load_pend = 1'b0;
        st_d.pready = apb_access && !st_q.pready;
        st_d.pslverr = apb_access && !st_q.pready && !addr_ok;
        st_d.prdata = 32'h0000_0000;
        if (st_q.win != 3'h0) begin
            st_d.win = st_q.win - 3'h1;
        end

        // Read data prepared during the wait cycle
        if (apb_access && !st_q.pready && !pwrite_i) begin
            case (paddr_i)
                SFS_OFF_CMD: begin
                    st_d.prdata[4:0] = st_q.cmd;
                    st_d.prdata[SFS_BIT_BUSY] = st_q.busy;
                end
                SFS_OFF_PTR: begin
                    st_d.prdata[15:0] = st_q.ptr;
                end
                SFS_OFF_DATA: begin
                    st_d.prdata[15:0] = st_q.data;
                end
                SFS_OFF_RESULT: begin
                    st_d.prdata[7:0] = st_q.result;
                end
                default: begin
                    st_d.prdata = 32'h0000_0000;
                end
            endcase
        end

        // Pointer and data pair
        if (apb_take && pwrite_i && (paddr_i == SFS_OFF_PTR)) begin
            if (pstrb_i[0]) begin
                st_d.ptr[7:0] = pwdata_i[7:0];
            end
            if (pstrb_i[1]) begin
                st_d.ptr[15:8] = pwdata_i[15:8];
            end
        end
        if (apb_take && pwrite_i && (paddr_i == SFS_OFF_DATA)) begin
            if (pstrb_i[0]) begin
                st_d.data[7:0] = pwdata_i[7:0];
            end
            if (pstrb_i[1]) begin
                st_d.data[15:8] = pwdata_i[15:8];
            end
        end

        // Window expiry without a store
        if (st_q.state == SFS_ARMED && st_q.win == SFS_WIN_LAST && !store_c) begin
            st_d.cmd = SFS_CMD_NONE;
            st_d.state = SFS_IDLE;
        end

        // Command write, ignored while the array is busy
        if (cmd_wr && cmd_valid && st_q.state != SFS_FLASH) begin
            st_d.cmd = pwdata_i[4:0];
            st_d.win = SFS_STORE_WIN;
            st_d.state = SFS_ARMED;
            if (pwdata_i[4:0] == SFS_CMD_REEN) begin
                buf_clr = 1'b1;
            end
        end

        // Store instruction inside the window
        if (store_c && st_q.state == SFS_ARMED) begin
            st_d.win = 3'h0;
            case (st_q.cmd)
                SFS_CMD_LOAD: begin
                    buf_we = 1'b1;
                    st_d.busy = 1'b0;
                    st_d.cmd = SFS_CMD_NONE;
                    st_d.state = SFS_IDLE;
                end
                SFS_CMD_ERASE, SFS_CMD_WRITE: begin
                    st_d.fcmd.start = 1'b1;
                    st_d.fcmd.op = (st_q.cmd == SFS_CMD_WRITE) ? SFS_OP_WRITE : SFS_OP_ERASE;
                    st_d.fcmd.addr = st_q.ptr & PAGE_MASK;
                    st_d.busy = st_q.busy || tgt_rww;
                    st_d.halt = !tgt_rww;
                    st_d.state = SFS_FLASH;
                end
                SFS_CMD_LOCK: begin
                    st_d.lock = st_q.lock &
                        {st_q.data[SFS_LOCK_SRC_MSB:SFS_LOCK_SRC_LSB], SFS_LOCK_LB_KEEP};
                    st_d.cmd = SFS_CMD_NONE;
                    st_d.state = SFS_IDLE;
                end
                SFS_CMD_REEN: begin
                    st_d.busy = 1'b0;
                    st_d.cmd = SFS_CMD_NONE;
                    st_d.state = SFS_IDLE;
                end
                default: begin
                    st_d.cmd = SFS_CMD_NONE;
                    st_d.state = SFS_IDLE;
                end
            endcase
        end

        // Running erase or write holds arm until the array is done
        if (st_q.state == SFS_FLASH && fl_done_i) begin
            if (st_q.fcmd.op == SFS_OP_WRITE) begin
                buf_clr = 1'b1;
            end
            st_d.fcmd.op = SFS_OP_NONE;
            st_d.cmd = SFS_CMD_NONE;
            st_d.halt = 1'b0;
            st_d.state = SFS_IDLE;
        end

        // Ordinary load result arrives one cycle after the address
        if (st_q.load_pend) begin
            if (st_q.busy && st_q.rd_addr < NO_READ_WHILE_WRITE_SECTION_BASE) begin
                st_d.result = SFS_BLOCKED_BYTE;
            end else begin
                st_d.result = fl_rd_byte_i;
            end
        end

        // Load instruction: lock or fuse readback, else byte read
        if (load_c) begin
            if (st_q.state == SFS_ARMED && st_q.cmd == SFS_CMD_LOCK &&
                    st_q.win >= SFS_LOAD_WIN_MIN) begin
                st_d.result = st_q.ptr[0] ? {SFS_LOCK_RD_PAD, st_q.lock} : fuse_s;
                st_d.cmd = SFS_CMD_NONE;
                st_d.state = SFS_IDLE;
            end else begin
                st_d.rd_addr = st_q.ptr;
                st_d.load_pend = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_s) begin
        if (!rst_n_s) begin
            st_q <= SFS_REGS_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Temporary page buffer
    // ****************************************************************
    sfs_page_buffer #(
        .WORD_BITS(WORD_BITS)
    ) u_buffer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_s),
        .clr_i(buf_clr),
        .we_i(buf_we),
        .waddr_i(st_q.ptr[WORD_BITS:1]),
        .wdata_i(st_q.data),
        .raddr_i(fl_buf_addr_i),
        .rdata_o(fl_buf_data_o)
    );

    assign prdata_o = st_q.prdata;
    assign pready_o = st_q.pready;
    assign pslverr_o = st_q.pslverr;
    assign fl_cmd_o = st_q.fcmd;
    assign fl_rd_addr_o = st_q.rd_addr;
    assign lock_bits_o = st_q.lock;
    assign cpu_halt_o = st_q.halt;
    assign section_busy_o = st_q.busy;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb_main @(posedge clk_i);
    endclocking

    default disable iff (!rst_n_s);

    a_arm_expiry: assert property (
        st_q.state == SFS_ARMED && st_q.win == SFS_WIN_LAST && !store_c && !cmd_wr
        |=> st_q.state == SFS_IDLE && st_q.cmd == SFS_CMD_NONE
    ) else $error("arm did not expire after the window");

    a_lock_program: assert property (
        store_c && st_q.state == SFS_ARMED && st_q.cmd == SFS_CMD_LOCK
        |=> st_q.lock == ($past(st_q.lock) & {$past(st_q.data[5:2]), 2'h3})
            && !st_q.cmd[SFS_BIT_LOCK]
    ) else $error("lock bits not programmed from low data");

    a_write_start: assert property (
        store_c && st_q.state == SFS_ARMED && st_q.cmd == SFS_CMD_WRITE
        |=> st_q.fcmd.start && st_q.fcmd.op == SFS_OP_WRITE ##1 !st_q.fcmd.start
    ) else $error("page write not started by store");

    a_arm_held: assert property (
        st_q.state == SFS_FLASH && !fl_done_i |=> st_q.cmd[SFS_BIT_ARM]
    ) else $error("arm dropped during flash operation");

    a_halt_no_read_while_write_section: assert property (
        st_q.fcmd.start && st_q.fcmd.addr >= NO_READ_WHILE_WRITE_SECTION_BASE
        |-> cpu_halt_o throughout (st_q.state == SFS_FLASH)[*2]
            or (cpu_halt_o ##1 st_q.state == SFS_IDLE)
    ) else $error("CPU not halted for non read-while-write page");

    a_bad_command: assert property (
        cmd_wr && !cmd_valid && st_q.state == SFS_IDLE
        |=> st_q.state == SFS_IDLE && st_q.cmd == SFS_CMD_NONE
    ) else $error("invalid command pattern took effect");

    a_addr_latch: assert property (
        st_q.state == SFS_FLASH && $past(st_q.state) == SFS_FLASH |-> $stable(st_q.fcmd.addr)
    ) else $error("latched flash address changed");

    a_busy_set: assert property (
        st_q.fcmd.start && st_q.fcmd.addr < NO_READ_WHILE_WRITE_SECTION_BASE |-> section_busy_o
    ) else $error("busy flag not set for read-while-write page");

    a_fuse_select: assert property (
        load_c && st_q.state == SFS_ARMED && st_q.cmd == SFS_CMD_LOCK &&
        st_q.win >= SFS_LOAD_WIN_MIN && !st_q.ptr[0]
        |=> st_q.result == $past(fuse_s)
    ) else $error("fuse readback wrong");

endmodule : sfs_sequencer

`default_nettype wire

// ---- verif/sfs_flash_model.sv ----
// Flash array stand-in that finishes operations after a set latency
`default_nettype none

module sfs_flash_model import sfs_pkg::*; (
    input wire logic clk_i,            // Clock
    input wire logic rst_n_i,          // Reset, active low
    input wire sfs_flash_cmd_t cmd_i,  // Command from sequencer
    input wire logic [3:0] lat_i,      // Busy cycles per operation
    input wire logic [15:0] rd_addr_i, // Byte address of load
    output logic done_o,               // Operation finished
    output logic [7:0] rd_byte_o       // Byte at that address
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run_q;
    logic [3:0] cnt_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_q <= 1'b0;
            cnt_q <= 4'h0;
        end else if (cmd_i.start) begin
            run_q <= 1'b1;
            cnt_q <= lat_i;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            run_q <= 1'b0;
        end
    end
    // One-cycle done pulse when the count runs out
    assign done_o = run_q && (cnt_q == 4'h0);
    assign rd_byte_o = rd_addr_i[7:0] ^ 8'hA5;
endmodule : sfs_flash_model

`default_nettype wire

// ---- verif/sfs_sequencer_tb.sv ----
// Self-checking bench for the flash self-programming sequencer
`default_nettype none

module sfs_sequencer_tb import sfs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, perr, pslverr, done, cpu_halt, sec_busy, held = 1'b0;
    logic [7:0] paddr = 8'h00, rd_byte;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] buf_data, rd_addr;
    logic [5:0] wbuf = 6'h00, lock_bits;
    logic [3:0] lat = 4'h3;
    sfs_flash_cmd_t fcmd;
    int err_total = 0, compares = 0;

    sfs_sequencer #(.WORD_BITS(6), .NO_READ_WHILE_WRITE_SECTION_BASE(16'h3800)) dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .fl_cmd_o(fcmd),
        .fl_done_i(done), .fl_buf_addr_i(wbuf), .fl_buf_data_o(buf_data),
        .fl_rd_addr_o(rd_addr), .fl_rd_byte_i(rd_byte), .fuse_i(8'h5C),
        .lock_bits_o(lock_bits), .cpu_halt_o(cpu_halt), .section_busy_o(sec_busy));
    sfs_flash_model flash_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(fcmd),
        .lat_i(lat), .rd_addr_i(rd_addr), .done_o(done), .rd_byte_o(rd_byte));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ****************
    // Bus and checks
    // ****************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Keep leaves psel high so the next setup follows at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic keep, output logic [31:0] r);
        if (!held) @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        penable <= 1'b0;
        if (!keep) psel <= 1'b0;
        held = keep;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic keep = 1'b0);
        logic [31:0] r;
        apb(1'b1, a, d, keep, r);
    endtask : wr

    task automatic wait_done;
        for (int i = 0; i < 40 && fcmd.op !== SFS_OP_NONE; i++) @(posedge clk_i);
        @(negedge clk_i);
        chk(fcmd.op, SFS_OP_NONE);
    endtask : wait_done

    task automatic bufchk(input logic [5:0] idx, input logic [15:0] exp);
        @(posedge clk_i);
        wbuf <= idx;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(buf_data, exp);
    endtask : bufchk

    // ****************
    // Scenarios
    // ****************
    task automatic t_ignored;
        logic [31:0] r;
        logic [4:0] bad [4] = '{5'h07, 5'h0F, 5'h13, 5'h02};
        logic [4:0] good [4] = '{5'h01, 5'h03, 5'h05, 5'h09};
        foreach (bad[i]) begin
            wr(SFS_OFF_CMD, {27'h0, bad[i]}, 1'b1);
            apb(1'b0, SFS_OFF_CMD, 32'h0, 1'b1, r);
            wr(SFS_OFF_ISSUE, 32'h1);
            @(negedge clk_i);
            chk(fcmd.op, SFS_OP_NONE);
            chk(r, 32'h0);
        end
        foreach (good[i]) begin
            wr(SFS_OFF_CMD, {27'h0, good[i]});
            wr(SFS_OFF_PTR, 32'h0100);
            apb(1'b0, SFS_OFF_CMD, 32'h0, 1'b0, r);
            chk(r, 32'h0);
        end
        wr(SFS_OFF_ISSUE, 32'h1);
        @(negedge clk_i);
        chk(fcmd.op, SFS_OP_NONE);
        chk(lock_bits, SFS_LOCK_RESET);
        apb(1'b0, 8'h14, 32'h0, 1'b0, r);
        chk(perr, 1'b1);
    endtask : t_ignored

    task automatic t_erase;
        logic [31:0] r;
        lat <= 4'hF;
        wr(SFS_OFF_PTR, 32'h0245);
        wr(SFS_OFF_CMD, 32'h03, 1'b1);
        wr(SFS_OFF_ISSUE, 32'h1);
        @(negedge clk_i);
        chk(fcmd, {1'b1, SFS_OP_ERASE, 16'h0200});
        chk({cpu_halt, sec_busy}, 2'b01);
        apb(1'b0, SFS_OFF_CMD, 32'h0, 1'b1, r);
        chk(r, 32'h43);
        wr(SFS_OFF_PTR, 32'h1000, 1'b1);
        wr(SFS_OFF_ISSUE, 32'h2, 1'b1);
        apb(1'b0, SFS_OFF_RESULT, 32'h0, 1'b0, r);
        chk(r, 32'hFF);
        chk(fcmd.addr, 16'h0200);
        wait_done();
        apb(1'b0, SFS_OFF_CMD, 32'h0, 1'b0, r);
        chk(r, 32'h40);
        wr(SFS_OFF_CMD, 32'h11, 1'b1);
        wr(SFS_OFF_ISSUE, 32'h1);
        apb(1'b0, SFS_OFF_CMD, 32'h0, 1'b0, r);
        chk(r, 32'h0);
    endtask : t_erase

    task automatic t_write;
        logic [31:0] r;
        logic [15:0] ld [3][2] = '{'{16'hBEEF, 16'h3920}, '{16'h1234, 16'h3905},
                                  '{16'h5555, 16'h3904}};
        lat <= 4'h3;
        foreach (ld[i]) begin
            wr(SFS_OFF_DATA, {16'h0, ld[i][0]});
            wr(SFS_OFF_PTR, {16'h0, ld[i][1]});
            wr(SFS_OFF_CMD, 32'h01, 1'b1);
            wr(SFS_OFF_ISSUE, 32'h1);
        end
        bufchk(6'h10, 16'hBEEF);
        bufchk(6'h02, 16'h1234);
        bufchk(6'h03, 16'hFFFF);
        wr(SFS_OFF_CMD, 32'h03, 1'b1);
        wr(SFS_OFF_ISSUE, 32'h1);
        @(negedge clk_i);
        chk({cpu_halt, sec_busy}, 2'b10);
        wait_done();
        wr(SFS_OFF_CMD, 32'h05, 1'b1);
        wr(SFS_OFF_ISSUE, 32'h1);
        @(negedge clk_i);
        chk(fcmd, {1'b1, SFS_OP_WRITE, 16'h3900});
        chk({cpu_halt, sec_busy}, 2'b10);
        wait_done();
        chk(cpu_halt, 1'b0);
        apb(1'b0, SFS_OFF_CMD, 32'h0, 1'b0, r);
        chk(r, 32'h0);
        bufchk(6'h02, 16'hFFFF);
    endtask : t_write

    task automatic t_lock;
        logic [31:0] r;
        logic [15:0] sel [3] = '{16'h0001, 16'h0000, 16'h3A77};
        logic [7:0] exp [3] = '{8'h1B, 8'h5C, 8'hD2};
        wr(SFS_OFF_DATA, 32'hFFD9);
        wr(SFS_OFF_CMD, 32'h09, 1'b1);
        wr(SFS_OFF_ISSUE, 32'h1);
        @(negedge clk_i);
        chk(lock_bits, 6'h1B);
        foreach (sel[i]) begin
            wr(SFS_OFF_PTR, {16'h0, sel[i]});
            if (i < 2) wr(SFS_OFF_CMD, 32'h09, 1'b1);
            wr(SFS_OFF_ISSUE, 32'h2, 1'b1);
            apb(1'b0, SFS_OFF_RESULT, 32'h0, 1'b0, r);
            chk(r, {24'h0, exp[i]});
        end
        chk(rd_addr, 16'h3A77);
    endtask : t_lock

    task automatic give_verdict;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_ignored();
        t_erase();
        t_write();
        t_lock();
        give_verdict();
    end

    initial begin
        repeat (3000) @(posedge clk_i);
        err_total++;
        give_verdict();
    end
endmodule : sfs_sequencer_tb

`default_nettype wire
